/* verilog/mmr_regs.vh */
`ifndef MMR_REGS_VH
`define MMR_REGS_VH

// Register indices as seen on the register port.
`define MMR_OFS_PHASE_A_CURRENT 12'h440
`define MMR_OFS_PHASE_B_CURRENT 12'h442
`define MMR_OFS_PHASE_C_CURRENT 12'h444
`define MMR_OFS_SENSE_GAIN 12'h468
`define MMR_OFS_VOLTAGE_RANGE 12'h472
`define MMR_OFS_SUPPLY_VOLTAGE 12'h476
`define MMR_OFS_PHASE_A_VOLTAGE 12'h47A
`define MMR_OFS_PHASE_B_VOLTAGE 12'h47C
`define MMR_OFS_PHASE_C_VOLTAGE 12'h47E
`define MMR_OFS_ANGLE_SINE 12'h4B6
`define MMR_OFS_ANGLE_COSINE 12'h4B8

// Widths.
`define MMR_ADDR_W 12
`define MMR_WORD_W 32
`define MMR_HALF_W 16
`define MMR_CODE_W 2

// Reset values.
`define MMR_RST_WORD 32'h00000000
`define MMR_RST_HALF 16'h0000
`define MMR_RST_CODE 2'h0

// Fixed-point scaling: values carry 27 fraction bits.
`define MMR_FRAC_BITS 27

// Sense gain codes, relative to the top sense amplifier gain.
`define MMR_SENSE_GAIN_X8 2'h0
`define MMR_SENSE_GAIN_X4 2'h1
`define MMR_SENSE_GAIN_X2 2'h2
`define MMR_SENSE_GAIN_X1 2'h3

// Voltage range codes (full scale).
`define MMR_RANGE_60V 2'h0
`define MMR_RANGE_30V 2'h1
`define MMR_RANGE_15V 2'h2

`endif

/* verilog/mmr_isd_capture.v */
`timescale 1ns/1ps
`include "mmr_regs.vh"

module mmr_isd_capture (
  input wire clk, // System clock.
  input wire reset_n, // Asynchronous reset, active low.
  input wire detect_active, // Initial speed detection in progress.
  input wire sample, // One-cycle strobe: phase voltages valid.
  input wire [`MMR_WORD_W-1:0] volt_a, // Phase A voltage sample.
  input wire [`MMR_WORD_W-1:0] volt_b, // Phase B voltage sample.
  input wire [`MMR_WORD_W-1:0] volt_c, // Phase C voltage sample.
  output reg [`MMR_WORD_W-1:0] cap_a, // Captured phase A voltage.
  output reg [`MMR_WORD_W-1:0] cap_b, // Captured phase B voltage.
  output reg [`MMR_WORD_W-1:0] cap_c, // Captured phase C voltage.
  output reg captured // A capture happened in the present or the last detection.
);

  reg detect_prev;
  wire take;
  wire detect_start;

  // Samples outside a detection are ignored so the last detection result stays readable.
  assign take = detect_active & sample;
  assign detect_start = detect_active & ~detect_prev;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_a <= `MMR_RST_WORD;
      cap_b <= `MMR_RST_WORD;
      cap_c <= `MMR_RST_WORD;
      captured <= 1'b0;
      detect_prev <= 1'b0;
    end else begin
      detect_prev <= detect_active;
      if (take) begin
        cap_a <= volt_a;
        cap_b <= volt_b;
        cap_c <= volt_c;
      end
      // A capture in the first cycle of a detection wins over the clear.
      if (take) begin
        captured <= 1'b1;
      end else if (detect_start) begin
        captured <= 1'b0;
      end
    end
  end

endmodule

/* verilog/mmr_readback.v */
// How it works
// - Three phase currents are held as 32-bit two's complement words.
// - Sense gain indicator is 16 bits; codes 0 to 3 mean gain x8, x4, x2, x1.
// - Voltage range indicator is 16 bits; codes 0, 1, 2 mean 60 V, 30 V, 15 V.
// - Supply bus voltage is an unsigned 32-bit word scaled by 60 over 2^27.
// - Phase voltages A, B, C are captured during initial speed detection.
// - Sine of commutation angle is a 32-bit two's complement word.
// - Cosine of commutation angle uses the same 32-bit signed scaling.
// - Every register of the bank reads zero after reset.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "mmr_regs.vh"

module mmr_readback (
  input wire CLK, // System clock, 40 MHz.
  input wire RESET_N, // Asynchronous reset, active low.
  input wire [`MMR_ADDR_W-1:0] ADDR, // Register index.
  input wire [`MMR_WORD_W-1:0] WDATA, // Write data, never stored.
  input wire WR, // Write strobe, one cycle.
  input wire RD, // Read strobe, one cycle.
  output reg [`MMR_WORD_W-1:0] RDATA, // Read data, cycle after RD.
  output reg WR_IGNORED, // Pulse: a host write to a mapped index was discarded.
  output reg ADDR_UNMAPPED, // Pulse: access to an unmapped index.
  input wire CUR_UPDATE, // Strobe: new phase currents.
  input wire [`MMR_WORD_W-1:0] CUR_A, // Phase A current.
  input wire [`MMR_WORD_W-1:0] CUR_B, // Phase B current.
  input wire [`MMR_WORD_W-1:0] CUR_C, // Phase C current.
  input wire SENSE_GAIN_UPDATE, // Strobe: new sense gain code.
  input wire [`MMR_CODE_W-1:0] SENSE_GAIN_CODE, // Sense gain code.
  input wire RANGE_UPDATE, // Strobe: new voltage range code.
  input wire [`MMR_CODE_W-1:0] RANGE_CODE, // Voltage range code.
  output reg CODE_REJECTED, // Pulse: reserved range code dropped.
  input wire SUPPLY_UPDATE, // Strobe: new supply bus voltage.
  input wire [`MMR_WORD_W-1:0] SUPPLY_VALUE, // Supply bus voltage.
  input wire INITIAL_SPEED_DETECT, // Initial speed detection running.
  input wire PHASE_V_SAMPLE, // Strobe: phase voltages valid.
  input wire [`MMR_WORD_W-1:0] PHASE_V_A, // Phase A voltage.
  input wire [`MMR_WORD_W-1:0] PHASE_V_B, // Phase B voltage.
  input wire [`MMR_WORD_W-1:0] PHASE_V_C, // Phase C voltage.
  output wire PHASE_V_CAPTURED, // A capture happened in this or the last detection.
  input wire ANGLE_UPDATE, // Strobe: new sine and cosine.
  input wire [`MMR_WORD_W-1:0] ANGLE_SINE, // Sine of commutation angle.
  input wire [`MMR_WORD_W-1:0] ANGLE_COSINE // Cosine of commutation angle.
);

  reg [`MMR_WORD_W-1:0] phase_a_current_reading;
  reg [`MMR_WORD_W-1:0] phase_b_current_reading;
  reg [`MMR_WORD_W-1:0] phase_c_current_reading;
  reg [`MMR_CODE_W-1:0] sense_amp_gain_indicator;
  reg [`MMR_CODE_W-1:0] voltage_range_indicator;
  reg [`MMR_WORD_W-1:0] supply_bus_voltage;
  reg [`MMR_WORD_W-1:0] angle_sine_value;
  reg [`MMR_WORD_W-1:0] angle_cosine_value;
  wire [`MMR_WORD_W-1:0] phase_a_voltage_capture;
  wire [`MMR_WORD_W-1:0] phase_b_voltage_capture;
  wire [`MMR_WORD_W-1:0] phase_c_voltage_capture;
  wire range_code_ok;
  wire addr_hit;
  reg [`MMR_WORD_W-1:0] next_rdata;

  // Index decode, shared by the read and the write paths.
  function is_mapped;
    input [`MMR_ADDR_W-1:0] idx;
    begin
      case (idx)
        `MMR_OFS_PHASE_A_CURRENT,
        `MMR_OFS_PHASE_B_CURRENT,
        `MMR_OFS_PHASE_C_CURRENT,
        `MMR_OFS_SENSE_GAIN,
        `MMR_OFS_VOLTAGE_RANGE,
        `MMR_OFS_SUPPLY_VOLTAGE,
        `MMR_OFS_PHASE_A_VOLTAGE,
        `MMR_OFS_PHASE_B_VOLTAGE,
        `MMR_OFS_PHASE_C_VOLTAGE,
        `MMR_OFS_ANGLE_SINE,
        `MMR_OFS_ANGLE_COSINE: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Places a gain or range code in the low bits of a 16-bit field.
  function [`MMR_WORD_W-1:0] half_word;
    input [`MMR_CODE_W-1:0] code;
    reg [`MMR_HALF_W-1:0] field;
    begin
      field = {{(`MMR_HALF_W-`MMR_CODE_W){1'b0}}, code};
      half_word = {{(`MMR_WORD_W-`MMR_HALF_W){1'b0}}, field};
    end
  endfunction

  // Read multiplexer; unmapped indices and idle cycles read zero. It is an open case and
  // not a function, since registers read inside a function body would not wake the process.
  always @* begin
    next_rdata = `MMR_RST_WORD;
    if (RD) begin
      case (ADDR)
        `MMR_OFS_PHASE_A_CURRENT: next_rdata = phase_a_current_reading;
        `MMR_OFS_PHASE_B_CURRENT: next_rdata = phase_b_current_reading;
        `MMR_OFS_PHASE_C_CURRENT: next_rdata = phase_c_current_reading;
        `MMR_OFS_SENSE_GAIN: next_rdata = half_word(sense_amp_gain_indicator);
        `MMR_OFS_VOLTAGE_RANGE: next_rdata = half_word(voltage_range_indicator);
        `MMR_OFS_SUPPLY_VOLTAGE: next_rdata = supply_bus_voltage;
        `MMR_OFS_PHASE_A_VOLTAGE: next_rdata = phase_a_voltage_capture;
        `MMR_OFS_PHASE_B_VOLTAGE: next_rdata = phase_b_voltage_capture;
        `MMR_OFS_PHASE_C_VOLTAGE: next_rdata = phase_c_voltage_capture;
        `MMR_OFS_ANGLE_SINE: next_rdata = angle_sine_value;
        `MMR_OFS_ANGLE_COSINE: next_rdata = angle_cosine_value;
        default: next_rdata = `MMR_RST_WORD;
      endcase
    end
  end

  // Code 3 has no meaning as a range, so it is dropped rather than shown.
  assign range_code_ok = (RANGE_CODE == `MMR_RANGE_60V) ||
                         (RANGE_CODE == `MMR_RANGE_30V) ||
                         (RANGE_CODE == `MMR_RANGE_15V);
  assign addr_hit = is_mapped(ADDR);

  mmr_isd_capture u_isd_capture (
    .clk(CLK),
    .reset_n(RESET_N),
    .detect_active(INITIAL_SPEED_DETECT),
    .sample(PHASE_V_SAMPLE),
    .volt_a(PHASE_V_A),
    .volt_b(PHASE_V_B),
    .volt_c(PHASE_V_C),
    .cap_a(phase_a_voltage_capture),
    .cap_b(phase_b_voltage_capture),
    .cap_c(phase_c_voltage_capture),
    .captured(PHASE_V_CAPTURED)
  );

  // The three currents load together so a read sees one consistent set.
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase_a_current_reading <= `MMR_RST_WORD;
      phase_b_current_reading <= `MMR_RST_WORD;
      phase_c_current_reading <= `MMR_RST_WORD;
    end else if (CUR_UPDATE) begin
      phase_a_current_reading <= CUR_A;
      phase_b_current_reading <= CUR_B;
      phase_c_current_reading <= CUR_C;
    end
  end

  // Every 2-bit code is a valid sense gain, so all updates are taken.
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sense_amp_gain_indicator <= `MMR_RST_CODE;
    end else if (SENSE_GAIN_UPDATE) begin
      sense_amp_gain_indicator <= SENSE_GAIN_CODE;
    end
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      voltage_range_indicator <= `MMR_RST_CODE;
      CODE_REJECTED <= 1'b0;
    end else begin
      CODE_REJECTED <= RANGE_UPDATE & ~range_code_ok;
      if (RANGE_UPDATE && range_code_ok) begin
        voltage_range_indicator <= RANGE_CODE;
      end
    end
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      supply_bus_voltage <= `MMR_RST_WORD;
    end else if (SUPPLY_UPDATE) begin
      supply_bus_voltage <= SUPPLY_VALUE;
    end
  end

  // Sine and cosine load as a pair so they always belong to one angle.
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      angle_sine_value <= `MMR_RST_WORD;
      angle_cosine_value <= `MMR_RST_WORD;
    end else if (ANGLE_UPDATE) begin
      angle_sine_value <= ANGLE_SINE;
      angle_cosine_value <= ANGLE_COSINE;
    end
  end

  // Host port. Write data is never stored anywhere; a write only raises a flag.
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= `MMR_RST_WORD;
      WR_IGNORED <= 1'b0;
      ADDR_UNMAPPED <= 1'b0;
    end else begin
      RDATA <= next_rdata;
      WR_IGNORED <= WR & addr_hit;
      ADDR_UNMAPPED <= (WR | RD) & ~addr_hit;
    end
  end

endmodule

/* sim/mmr_readback_assertions.sv */
`timescale 1ns/1ps
`include "mmr_regs.vh"
module mmr_readback_chk (
  input wire CLK, // Clock.
  input wire RESET_N, // Reset, active low.
  input wire [`MMR_ADDR_W-1:0] ADDR, // Index.
  input wire WR, // Write strobe.
  input wire RD, // Read strobe.
  input wire [`MMR_WORD_W-1:0] RDATA, // Read data.
  input wire WR_IGNORED, // Write dropped.
  input wire ADDR_UNMAPPED, // Bad index.
  input wire RANGE_UPDATE, // Range strobe.
  input wire [`MMR_CODE_W-1:0] RANGE_CODE, // Range code.
  input wire CODE_REJECTED, // Range dropped.
  input wire SUPPLY_UPDATE, // Supply strobe.
  input wire [`MMR_WORD_W-1:0] SUPPLY_VALUE, // Supply value.
  input wire INITIAL_SPEED_DETECT, // Detection level.
  input wire PHASE_V_SAMPLE, // Sample strobe.
  input wire PHASE_V_CAPTURED, // Capture flag.
  input wire ANGLE_UPDATE, // Angle strobe.
  input wire [`MMR_WORD_W-1:0] ANGLE_SINE // Sine input.
);
  wire mapped = ADDR inside {12'h440, 12'h442, 12'h444, 12'h468, 12'h472, 12'h476,
    12'h47A, 12'h47C, 12'h47E, 12'h4B6, 12'h4B8};
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  AST_WR_IGNORED: assert property (WR && mapped |=> WR_IGNORED)
    else $error("mapped write not flagged");
  AST_NO_IGNORE: assert property (!(WR && mapped) |=> !WR_IGNORED)
    else $error("spurious write flag");
  AST_UNMAPPED: assert property ((WR || RD) && !mapped |=> ADDR_UNMAPPED && RDATA == 32'h0)
    else $error("unmapped access not flagged");
  AST_IDLE_DATA: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data outside read cycle");
  AST_GAIN_FIELD: assert property (RD && ADDR == 12'h468 |=> RDATA[31:2] == 30'h0)
    else $error("gain indicator upper bits set");
  AST_RANGE_FIELD: assert property (
    RD && ADDR == 12'h472 |=> RDATA[31:2] == 30'h0 && RDATA[1:0] != 2'h3)
    else $error("range indicator out of set");
  AST_RANGE_REJECT: assert property (
    RANGE_UPDATE |=> CODE_REJECTED == ($past(RANGE_CODE) == 2'h3))
    else $error("range rejection wrong");
  AST_CAPTURE: assert property (INITIAL_SPEED_DETECT && PHASE_V_SAMPLE |=> PHASE_V_CAPTURED)
    else $error("capture flag not set");
  AST_CAPTURE_HOLD: assert property (
    PHASE_V_CAPTURED && !$rose(INITIAL_SPEED_DETECT) |=> PHASE_V_CAPTURED)
    else $error("capture flag lost");
  AST_SUPPLY_READ: assert property (
    SUPPLY_UPDATE ##1 (RD && ADDR == 12'h476 && !SUPPLY_UPDATE)
    |=> RDATA == $past(SUPPLY_VALUE, 2))
    else $error("supply value not returned");
  AST_SINE_READ: assert property (
    ANGLE_UPDATE ##1 (RD && ADDR == 12'h4B6 && !ANGLE_UPDATE)
    |=> RDATA == $past(ANGLE_SINE, 2))
    else $error("sine value not returned");
  cover property (WR && mapped);
  cover property (RANGE_UPDATE && RANGE_CODE == 2'h3);
  cover property (INITIAL_SPEED_DETECT && PHASE_V_SAMPLE);
endmodule
bind mmr_readback mmr_readback_chk u_mmr_readback_chk (.*);

/* sim/mmr_readback_test.sv */
`timescale 1ns/1ps
`include "mmr_regs.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module mmr_readback_test;
  logic CLK = 0, RESET_N = 0, WR = 0, RD = 0, CUR_UPDATE = 0, SENSE_GAIN_UPDATE = 0;
  logic RANGE_UPDATE = 0, SUPPLY_UPDATE = 0, INITIAL_SPEED_DETECT = 0, PHASE_V_SAMPLE = 0;
  logic ANGLE_UPDATE = 0;
  logic [11:0] ADDR = 0;
  logic [1:0] SENSE_GAIN_CODE = 0, RANGE_CODE = 0;
  logic [31:0] WDATA = 0, CUR_A = 0, CUR_B = 0, CUR_C = 0, SUPPLY_VALUE = 0, PHASE_V_A = 0;
  logic [31:0] PHASE_V_B = 0, PHASE_V_C = 0, ANGLE_SINE = 0, ANGLE_COSINE = 0, RDATA;
  logic WR_IGNORED, ADDR_UNMAPPED, CODE_REJECTED, PHASE_V_CAPTURED;
  int bad_count = 0, n_tests = 0;
  logic [43:0] rows [11] = '{
    {12'h4B6, 32'hF8000000}, {12'h4B8, 32'h08000000}, {12'h440, 32'h80000001},
    {12'h442, 32'h7FFFFFFF}, {12'h444, 32'hFFFFFFFF}, {12'h468, 32'h00000003},
    {12'h472, 32'h00000002}, {12'h476, 32'hF0000000}, {12'h47A, 32'h11111111},
    {12'h47C, 32'h22222222}, {12'h47E, 32'h33333333}};
  mmr_readback u_mmr_readback (.*);
  always #12.5 CLK = ~CLK;
  // Every bus task drops the update strobes, so an update raised before it lasts one cycle.
  task automatic clr;
    {CUR_UPDATE, SENSE_GAIN_UPDATE, RANGE_UPDATE, SUPPLY_UPDATE} <= 4'h0;
    {PHASE_V_SAMPLE, ANGLE_UPDATE} <= 2'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge CLK);
    clr();
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 `CHK(RDATA, e)
  endtask
  task automatic wr(input logic [11:0] a, input logic ign, input logic unm);
    @(posedge CLK);
    clr();
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= 32'hA5A5A5A5;
    @(posedge CLK);
    WR <= 1'b0;
    #1 `CHK({WR_IGNORED, ADDR_UNMAPPED}, {ign, unm})
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #50000;
    bad_count++;
    $display("unexpected at %0t: run did not finish", $time);
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge CLK);
    RESET_N <= 1'b1;
    `CHK({WR_IGNORED, ADDR_UNMAPPED, CODE_REJECTED, PHASE_V_CAPTURED}, 4'h0)
    foreach (rows[i]) rd(rows[i][43:32], 32'h0);
    $display("reset values done");
    @(posedge CLK);
    {CUR_UPDATE, SENSE_GAIN_UPDATE, RANGE_UPDATE, SUPPLY_UPDATE} <= 4'hF;
    {INITIAL_SPEED_DETECT, PHASE_V_SAMPLE, ANGLE_UPDATE} <= 3'h7;
    {CUR_A, CUR_B, CUR_C} <= {rows[2][31:0], rows[3][31:0], rows[4][31:0]};
    SENSE_GAIN_CODE <= 2'h3;
    RANGE_CODE <= 2'h2;
    SUPPLY_VALUE <= rows[7][31:0];
    {PHASE_V_A, PHASE_V_B, PHASE_V_C} <= {rows[8][31:0], rows[9][31:0], rows[10][31:0]};
    {ANGLE_SINE, ANGLE_COSINE} <= {rows[0][31:0], rows[1][31:0]};
    foreach (rows[i]) rd(rows[i][43:32], rows[i][31:0]);
    `CHK(PHASE_V_CAPTURED, 1'b1)
    $display("table done");
    foreach (rows[i]) begin
      wr(rows[i][43:32], 1'b1, 1'b0);
      rd(rows[i][43:32], rows[i][31:0]);
    end
    wr(12'h441, 1'b0, 1'b1);
    rd(12'h441, 32'h0);
    `CHK(ADDR_UNMAPPED, 1'b1)
    $display("write protection done");
    for (int c = 0; c < 4; c++) begin
      @(posedge CLK);
      SENSE_GAIN_UPDATE <= 1'b1;
      RANGE_UPDATE <= 1'b1;
      SENSE_GAIN_CODE <= c[1:0];
      RANGE_CODE <= c[1:0];
      @(posedge CLK);
      clr();
      #1 `CHK(CODE_REJECTED, 1'(c == 3))
      rd(12'h468, {30'h0, c[1:0]});
      rd(12'h472, {30'h0, (c == 3) ? 2'h2 : c[1:0]});
    end
    @(posedge CLK);
    SUPPLY_UPDATE <= 1'b1;
    SUPPLY_VALUE <= 32'h00000001;
    rd(12'h476, 32'h00000001);
    $display("codes done");
    @(posedge CLK);
    INITIAL_SPEED_DETECT <= 1'b0;
    PHASE_V_SAMPLE <= 1'b1;
    {PHASE_V_A, PHASE_V_B, PHASE_V_C} <= {3{32'hDEADBEEF}};
    rd(12'h47A, rows[8][31:0]);
    `CHK(PHASE_V_CAPTURED, 1'b1)
    @(posedge CLK);
    INITIAL_SPEED_DETECT <= 1'b1;
    rd(12'h47E, rows[10][31:0]);
    `CHK(PHASE_V_CAPTURED, 1'b0)
    @(posedge CLK);
    PHASE_V_SAMPLE <= 1'b1;
    rd(12'h47C, 32'hDEADBEEF);
    $display("capture done");
    @(posedge CLK);
    RESET_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RESET_N <= 1'b1;
    rd(12'h4B8, 32'h0);
    rd(12'h47C, 32'h0);
    $display("second reset done");
    end_of_test();
  end
endmodule
